/* File: pkg/wof_defines.vh */
// Shared constants for the write-once flag and correction link block
`ifndef WOF_DEFINES_VH
`define WOF_DEFINES_VH
// ============================================================
// Checksum
`define WOF_CRC_POLY    8'h85
`define WOF_CRC_INIT    8'hFF
`define WOF_VALID_SYNC  8'h0D
// ============================================================
// Correction vector packet
`define WOF_VEC_SYNC    4'hD
`define WOF_VEC_BITS    6'h2A
`define WOF_VEC_BODY    6'h22
// ============================================================
// Flag field
`define WOF_FLAG_THRESH 5'h0C
`define WOF_FLAG_BYTES  3'h5
`define WOF_HALF_SHORT  3'h4
`define WOF_HALF_LONG   3'h5
`define WOF_MODE_FLAG_A 3'h4
`define WOF_MODE_FLAG_B 3'h5
// ============================================================
// Erasure pointer bit positions
`define WOF_EP_RLL      0
`define WOF_EP_DECODE   1
`define WOF_EP_RESYNC   2
`define WOF_EP_LOCK     3
`endif

/* File: design/wof_flag_counter.v */
// Transition counter for flag field detection
`timescale 1ns/1ps
`default_nettype none
`include "wof_defines.vh"
module wof_flag_counter (
   // Clock and reset
   input  wire       i_ref_clk,
   input  wire       i_reset,
   // Sampled inputs
   input  wire       i_raw,
   input  wire       i_ref_edge,
   input  wire       i_window,
   input  wire       i_clear,
   // Result
   output reg  [4:0] o_count,
   output wire       o_over
);
   reg       raw_q;
   reg [2:0] half_cnt;
   wire      fall = raw_q & ~i_raw;
   // Half periods of the reference clock; under two periods is four halves
   always @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         raw_q    <= 1'b0;
         half_cnt <= 3'h0;
         o_count  <= 5'h00;
      end else begin
         raw_q <= i_raw;
         if (!i_raw)
            half_cnt <= 3'h0;
         else if (i_ref_edge && half_cnt != 3'h7)
            half_cnt <= half_cnt + 3'h1;
         if (i_clear)
            o_count <= 5'h00;
         else if (i_window && fall && o_count < 5'h1E) begin
            // Width between the two limits counts once: no double count on doubt
            if (half_cnt > `WOF_HALF_LONG)
               o_count <= o_count + 5'h02;
            else
               o_count <= o_count + 5'h01;
         end
      end
   end
   assign o_over = (o_count > `WOF_FLAG_THRESH);
endmodule // wof_flag_counter
`default_nettype wire

/* File: design/wof_vector_tx.v */
// Serial sender of correction vectors with ready/fault handshake
`timescale 1ns/1ps
`default_nettype none
`include "wof_defines.vh"
module wof_vector_tx #(
   parameter BIT_CYCLES = 4
) (
   // Clock and reset
   input  wire        i_ref_clk,
   input  wire        i_reset,
   // Vector request
   input  wire        i_start,
   input  wire [21:0] i_addr,
   input  wire [7:0]  i_pattern,
   // Link, already synchronised
   input  wire        i_ready,
   input  wire        i_fault,
   // Status
   output reg         o_serial,
   output wire        o_idle,
   output reg         o_error
);
   localparam ST_IDLE = 2'b00;
   localparam ST_SEND = 2'b01;
   localparam ST_WAIT = 2'b10;
   reg [1:0]  state;
   reg [41:0] shreg;
   reg [5:0]  bits;
   reg [7:0]  div;
   wire [33:0] body = {`WOF_VEC_SYNC, i_addr, i_pattern};
   function [7:0] crc_bits;
      input [33:0] d;
      integer k;
      reg [7:0] c;
      begin
         c = `WOF_CRC_INIT;
         for (k = 33; k >= 0; k = k - 1)
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[k]) ? `WOF_CRC_POLY : 8'h00);
         crc_bits = c;
      end
   endfunction
   assign o_idle = (state == ST_IDLE);
   always @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         state    <= ST_IDLE;
         shreg    <= 42'h0;
         bits     <= 6'h00;
         div      <= 8'h00;
         o_serial <= 1'b0;
         o_error  <= 1'b0;
      end else begin
         o_error <= 1'b0;
         case (state)
            ST_IDLE: begin
               o_serial <= 1'b0;
               if (i_start && i_ready) begin
                  shreg <= {body, crc_bits(body)};
                  bits  <= 6'h00;
                  div   <= 8'h00;
                  state <= ST_SEND;
               end
            end
            ST_SEND: begin
               o_serial <= shreg[41];
               if (div == BIT_CYCLES - 1) begin
                  div   <= 8'h00;
                  shreg <= {shreg[40:0], 1'b0};
                  bits  <= bits + 6'h01;
                  if (bits == 6'h04 && i_ready) begin
                     o_error <= 1'b1;
                     state   <= ST_IDLE;
                  end else if (bits == `WOF_VEC_BITS - 6'h01)
                     state <= ST_WAIT;
               end else
                  div <= div + 8'h01;
            end
            ST_WAIT: begin
               o_serial <= 1'b0;
               if (i_fault) begin
                  o_error <= 1'b1;
                  state   <= ST_IDLE;
               end else if (i_ready)
                  state <= ST_IDLE;
            end
            default: state <= ST_IDLE;
         endcase
      end
   end
endmodule // wof_vector_tx
`default_nettype wire

/* File: design/wof_link.v */
// Write-once flag handling, write gate, correction vectors and data checksum
// ============================================================
`timescale 1ns/1ps
`default_nettype none
`include "wof_defines.vh"
module wof_link #(
   parameter       FLAG_GAP_BYTES = 4,
   parameter [7:0] FLAG_PATTERN   = 8'hFF,
   parameter       BIT_CYCLES     = 4
) (
   // Clock and reset
   input  wire        i_ref_clk,
   input  wire        i_reset,
   // Disk side pins
   input  wire        i_raw_read_input,
   input  wire        i_reference_double_clock,
   output reg         o_disk_write_gate,
   // Sector timing from the format sequencer
   input  wire        i_byte_tick,
   input  wire        i_id_ok,
   input  wire        i_pseudo_mark,
   input  wire        i_id_voting_met,
   input  wire        i_sm_met,
   input  wire        i_data_field,
   input  wire        i_sector_end,
   // Operation control
   input  wire [2:0]  i_op_mode,
   input  wire        i_write_sector,
   input  wire        i_read_sector,
   input  wire        i_flag_abort_en,
   input  wire        i_need_sm,
   input  wire        i_need_id,
   input  wire        i_need_flag_clear,
   input  wire        i_error_reset,
   // Flag status
   output reg         o_flag_written,
   output reg         o_flag_irq,
   output reg         o_write_aborted,
   output reg  [7:0]  o_flag_byte,
   output reg         o_flag_byte_strobe,
   // Corrector vectors
   input  wire        i_vec_valid,
   input  wire [21:0] i_vec_addr,
   input  wire [7:0]  i_vec_pattern,
   output reg         o_vec_accept,
   output reg         o_corrector_overrun,
   // Correction link pins
   output reg         o_fix_serial,
   input  wire        i_fix_ready,
   input  wire        i_fix_fault,
   output reg         o_vector_error,
   output reg         o_read_halt,
   // Data line
   input  wire        i_nrz_start,
   input  wire        i_nrz_valid,
   input  wire [7:0]  i_nrz_byte,
   input  wire        i_nrz_check,
   input  wire [7:0]  i_nrz_remote,
   input  wire        i_crc_irq_en,
   output reg  [7:0]  o_nrz_crc,
   output reg         o_crc_mismatch,
   output reg         o_crc_irq,
   // Erasure pointers to the buffer
   input  wire        i_erasure_en,
   input  wire        i_rll_violation,
   input  wire        i_bad_decode,
   input  wire        i_resync_used,
   input  wire        i_lock_lost,
   output reg  [7:0]  o_buf_byte,
   output reg         o_buf_valid
);
   // ============================================================
   // Pin synchronisers
   reg [1:0] raw_sync;
   reg [1:0] ref_sync;
   reg [1:0] rdy_sync;
   reg [1:0] flt_sync;
   reg       ref_q;
   always @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         raw_sync <= 2'b00;
         ref_sync <= 2'b00;
         rdy_sync <= 2'b00;
         flt_sync <= 2'b00;
         ref_q    <= 1'b0;
      end else begin
         raw_sync <= {raw_sync[0], i_raw_read_input};
         ref_sync <= {ref_sync[0], i_reference_double_clock};
         rdy_sync <= {rdy_sync[0], i_fix_ready};
         flt_sync <= {flt_sync[0], i_fix_fault};
         ref_q    <= ref_sync[1];
      end
   end
   // Both edges count: the counter works in half periods of the reference
   wire ref_edge = ref_q ^ ref_sync[1];

   // ============================================================
   // Flag field window timing
   reg [7:0] gap_cnt;
   reg [2:0] win_cnt;
   reg       timing;
   reg       window;
   wire      flag_gen_mode = (i_op_mode == `WOF_MODE_FLAG_A) ||
                             (i_op_mode == `WOF_MODE_FLAG_B);
   wire      restart = i_id_ok || (i_pseudo_mark && !i_id_voting_met);
   always @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         gap_cnt <= 8'h00;
         win_cnt <= 3'h0;
         timing  <= 1'b0;
         window  <= 1'b0;
      end else if (restart) begin
         gap_cnt <= 8'h00;
         win_cnt <= 3'h0;
         timing  <= 1'b1;
         window  <= 1'b0;
      end else if (i_byte_tick) begin
         if (timing && !window) begin
            if (gap_cnt == FLAG_GAP_BYTES - 1) begin
               window <= 1'b1;
               timing <= 1'b0;
            end else
               gap_cnt <= gap_cnt + 8'h01;
         end else if (window) begin
            if (win_cnt == `WOF_FLAG_BYTES - 3'h1)
               window <= 1'b0;
            else
               win_cnt <= win_cnt + 3'h1;
         end
      end
   end

   // ============================================================
   // Detection
   wire [4:0] flag_count;
   wire       flag_over;
   wire       generating = window && flag_gen_mode && i_id_voting_met;
   wof_flag_counter u_flag_counter (
      .i_ref_clk (i_ref_clk),
      .i_reset   (i_reset),
      .i_raw     (raw_sync[1]),
      .i_ref_edge(ref_edge),
      .i_window  (window && !generating),
      .i_clear   (restart),
      .o_count   (flag_count),
      .o_over    (flag_over)
   );
   wire abort_now = flag_over && i_write_sector && i_flag_abort_en;
   wire prereq_ok = (!i_need_sm || i_sm_met) &&
                    (!i_need_id || i_id_voting_met) &&
                    (!i_need_flag_clear || !(o_flag_written || flag_over));
   always @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         o_flag_written     <= 1'b0;
         o_flag_irq         <= 1'b0;
         o_write_aborted    <= 1'b0;
         o_disk_write_gate  <= 1'b0;
         o_flag_byte        <= 8'h00;
         o_flag_byte_strobe <= 1'b0;
      end else begin
         if (flag_over)
            o_flag_written <= 1'b1;
         else if (i_error_reset)
            o_flag_written <= 1'b0;
         if (abort_now)
            o_flag_irq <= 1'b1;
         else if (i_error_reset)
            o_flag_irq <= 1'b0;
         if (abort_now)
            o_write_aborted <= 1'b1;
         else if (!i_write_sector)
            o_write_aborted <= 1'b0;
         // Gate: flag generation, or a data field write that passed its checks
         o_disk_write_gate <= generating ||
                              (i_write_sector && i_data_field && prereq_ok &&
                               !abort_now && !o_write_aborted);
         o_flag_byte        <= generating ? FLAG_PATTERN : 8'h00;
         o_flag_byte_strobe <= generating && i_byte_tick;
      end
   end

   // ============================================================
   // Correction vectors
   wire tx_idle;
   wire tx_serial;
   wire tx_error;
   wof_vector_tx #(
      .BIT_CYCLES(BIT_CYCLES)
   ) u_vector_tx (
      .i_ref_clk(i_ref_clk),
      .i_reset  (i_reset),
      .i_start  (i_vec_valid && !o_read_halt),
      .i_addr   (i_vec_addr),
      .i_pattern(i_vec_pattern),
      .i_ready  (rdy_sync[1]),
      .i_fault  (flt_sync[1]),
      .o_serial (tx_serial),
      .o_idle   (tx_idle),
      .o_error  (tx_error)
   );
   always @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         o_fix_serial        <= 1'b0;
         o_vec_accept        <= 1'b0;
         o_corrector_overrun <= 1'b0;
         o_vector_error      <= 1'b0;
         o_read_halt         <= 1'b0;
      end else begin
         o_fix_serial <= tx_serial;
         o_vec_accept <= i_vec_valid && tx_idle && rdy_sync[1] &&
                         !o_read_halt && !o_vec_accept;
         // Vectors still queued when the next sector ends mean the corrector fell behind
         if (i_sector_end && i_vec_valid && i_read_sector)
            o_corrector_overrun <= 1'b1;
         else if (i_error_reset)
            o_corrector_overrun <= 1'b0;
         if (tx_error)
            o_vector_error <= 1'b1;
         else if (i_error_reset)
            o_vector_error <= 1'b0;
         if (tx_error && i_read_sector)
            o_read_halt <= 1'b1;
         else if (i_error_reset)
            o_read_halt <= 1'b0;
      end
   end

   // ============================================================
   // Data line checksum and erasure pointers
   function [7:0] crc_byte;
      input [7:0] c_in;
      input [7:0] d;
      integer k;
      reg [7:0] c;
      begin
         c = c_in;
         for (k = 7; k >= 0; k = k - 1)
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[k]) ? `WOF_CRC_POLY : 8'h00);
         crc_byte = c;
      end
   endfunction
   wire       any_erasure = i_rll_violation | i_bad_decode | i_resync_used | i_lock_lost;
   wire [7:0] pointer = {4'h0, i_lock_lost, i_resync_used, i_bad_decode, i_rll_violation};
   // Start byte (0D on read, first sync mark byte on write) is itself included
   wire [7:0] crc_base = i_nrz_start ? `WOF_CRC_INIT : o_nrz_crc;
   always @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         o_nrz_crc      <= 8'hFF;
         o_crc_mismatch <= 1'b0;
         o_crc_irq      <= 1'b0;
         o_buf_byte     <= 8'h00;
         o_buf_valid    <= 1'b0;
      end else begin
         if (i_nrz_valid)
            o_nrz_crc <= crc_byte(crc_base, i_nrz_byte);
         else if (i_nrz_start)
            o_nrz_crc <= `WOF_CRC_INIT;
         if (i_nrz_check && i_nrz_remote != o_nrz_crc)
            o_crc_mismatch <= 1'b1;
         else if (i_error_reset)
            o_crc_mismatch <= 1'b0;
         if (i_nrz_check && i_nrz_remote != o_nrz_crc && i_write_sector && i_crc_irq_en)
            o_crc_irq <= 1'b1;
         else if (i_error_reset)
            o_crc_irq <= 1'b0;
         o_buf_valid <= i_nrz_valid && i_read_sector;
         if (i_erasure_en && any_erasure)
            o_buf_byte <= pointer;
         else
            o_buf_byte <= i_nrz_byte;
      end
   end
endmodule // wof_link
`default_nettype wire

/* File: verif/wof_link_assertions.sv */
// Concurrent checks on the ports of the link block
`timescale 1ns/1ps
`default_nettype none
module wof_link_assertions #(
   parameter BIT_CYCLES = 4
) (
   // Watched ports
   input wire logic       i_ref_clk,
   input wire logic       i_reset,
   input wire logic [2:0] i_op_mode,
   input wire logic       i_need_sm,
   input wire logic       i_sm_met,
   input wire logic       i_nrz_start,
   input wire logic       i_nrz_valid,
   input wire logic       i_erasure_en,
   input wire logic       i_lock_lost,
   input wire logic       i_fix_ready,
   input wire logic       i_error_reset,
   input wire logic       o_disk_write_gate,
   input wire logic       o_write_aborted,
   input wire logic       o_flag_written,
   input wire logic       o_flag_irq,
   input wire logic       o_vec_accept,
   input wire logic       o_fix_serial,
   input wire logic       o_vector_error,
   input wire logic       o_read_halt,
   input wire logic [7:0] o_nrz_crc,
   input wire logic [7:0] o_buf_byte,
   input wire logic       o_buf_valid
);
   // ============================================================
   // Properties
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_reset);
   logic no_gen;
   // Flag generation may drive the gate on its own, so gate checks skip it
   assign no_gen = i_op_mode[2:1] != 2'b10;
   property p_crc_preset; i_nrz_start && !i_nrz_valid |=> o_nrz_crc == 8'hFF; endproperty
   a_crc_preset: assert property (p_crc_preset) else $error("checksum not preset");
   property p_sync_bits;
      o_vec_accept |=> ##1 o_fix_serial [*8] ##1 !o_fix_serial [*4] ##1 o_fix_serial [*4];
   endproperty
   a_sync_bits: assert property (p_sync_bits) else $error("bad sync field");
   property p_one_accept; o_vec_accept |=> !o_vec_accept [*8]; endproperty
   a_one_accept: assert property (p_one_accept) else $error("packet overlap");
   property p_ready_low; !i_fix_ready [*5] |-> !o_vec_accept; endproperty
   a_ready_low: assert property (p_ready_low) else $error("accept with ready low");
   property p_halt_blocks; $past(o_read_halt) |-> !o_vec_accept; endproperty
   a_halt_blocks: assert property (p_halt_blocks) else $error("accept while halted");
   property p_err_sticky; o_vector_error && !i_error_reset |=> o_vector_error; endproperty
   a_err_sticky: assert property (p_err_sticky) else $error("vector error lost");
   property p_halt_err; $rose(o_read_halt) |-> o_vector_error; endproperty
   a_halt_err: assert property (p_halt_err) else $error("halt without error");
   property p_abort_gate; o_write_aborted && no_gen |=> !o_disk_write_gate; endproperty
   a_abort_gate: assert property (p_abort_gate) else $error("gate after abort");
   property p_gate_prereq; i_need_sm && !i_sm_met && no_gen |=> !o_disk_write_gate; endproperty
   a_gate_prereq: assert property (p_gate_prereq) else $error("gate without mark");
   property p_erasure;
      i_nrz_valid && i_erasure_en && i_lock_lost |=> o_buf_valid && o_buf_byte[3];
   endproperty
   a_erasure: assert property (p_erasure) else $error("no lock pointer");
   property p_flag_irq; $rose(o_flag_irq) |-> ##[0:1] o_flag_written; endproperty
   a_flag_irq: assert property (p_flag_irq) else $error("irq without flag");
endmodule // wof_link_assertions
bind wof_link wof_link_assertions #(.BIT_CYCLES(BIT_CYCLES)) i_wof_link_assertions (.*);
`default_nettype wire

/* File: verif/wof_fix_partner.sv */
// Behavioural model of the companion controller receiving correction vectors
`timescale 1ns/1ps
`default_nettype none
module wof_fix_partner #(
   parameter BIT_CYCLES = 4
) (
   // Link
   input  wire logic        i_ref_clk,
   input  wire logic        i_reset,
   input  wire logic        i_serial,
   // 0 normal, 1 misses the sync field, 2 cannot fix the byte
   input  wire logic [1:0]  i_mode,
   input  wire logic [7:0]  i_delay,
   output var  logic        o_ready,
   output var  logic        o_fault,
   // Last packet received
   output var  logic [33:0] o_body,
   output var  logic        o_crc_ok,
   output var  int          o_count
);
   // ============================================================
   // Receiver
   int          cnt;
   int          wt;
   logic        busy;
   logic [41:0] sh;
   logic [41:0] v;
   function automatic logic [7:0] crc34(input logic [33:0] b);
      logic [7:0] c;
      c = 8'hFF;
      for (int k = 33; k >= 0; k--) c = {c[6:0], 1'b0} ^ ((c[7] ^ b[k]) ? 8'h85 : 8'h00);
      return c;
   endfunction
   assign v = {sh[40:0], i_serial};
   always @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         o_ready <= 1'b1;
         o_fault <= 1'b0;
         o_body <= 34'h0;
         o_crc_ok <= 1'b0;
         o_count <= 0;
         busy <= 1'b0;
         cnt <= 0;
         wt <= 0;
         sh <= 42'h0;
      end else if (wt > 0) begin
         wt <= wt - 1;
         if (wt == 1) o_ready <= 1'b1;
      end else if (busy) begin
         cnt <= cnt + 1;
         if (cnt % BIT_CYCLES == 0) sh <= v;
         // Ready falls on the fourth sync bit, early enough for the sender's check
         if (cnt == 3 * BIT_CYCLES && v[3:0] == 4'hD && i_mode != 2'h1) o_ready <= 1'b0;
         if (cnt == 41 * BIT_CYCLES) begin
            busy <= 1'b0;
            o_count <= o_count + 1;
            o_body <= v[41:8];
            o_crc_ok <= crc34(v[41:8]) == v[7:0];
            if (i_mode == 2'h2 || (i_mode == 2'h0 && crc34(v[41:8]) != v[7:0])) o_fault <= 1'b1;
            else if (i_mode == 2'h0) wt <= i_delay + 1;
         end
      end else if (i_serial && !o_fault) begin
         busy <= 1'b1;
         cnt <= 1;
         sh <= 42'h1;
      end
   end
endmodule // wof_fix_partner
`default_nettype wire

/* File: verif/wof_link_tb.sv */
// Self-checking testbench for the write-once flag and correction link block
`timescale 1ns/1ps
`default_nettype none
module wof_link_tb;
   // ============================================================
   // Connections and bench state
   logic        i_ref_clk, i_reset, i_raw_read_input, i_reference_double_clock, i_byte_tick;
   logic        i_id_ok, i_pseudo_mark, i_id_voting_met, i_sm_met, i_data_field, i_sector_end;
   logic        i_write_sector, i_read_sector, i_flag_abort_en, i_need_sm, i_need_id;
   logic        i_need_flag_clear, i_error_reset, i_vec_valid, i_fix_ready, i_fix_fault;
   logic        i_nrz_start, i_nrz_valid, i_nrz_check, i_crc_irq_en, i_erasure_en;
   logic        i_rll_violation, i_bad_decode, i_resync_used, i_lock_lost;
   logic [2:0]  i_op_mode;
   logic [21:0] i_vec_addr, a;
   logic [7:0]  i_vec_pattern, i_nrz_byte, i_nrz_remote, o_flag_byte, o_nrz_crc, o_buf_byte;
   logic        o_disk_write_gate, o_flag_written, o_flag_irq, o_write_aborted, o_fix_serial;
   logic        o_flag_byte_strobe, o_vec_accept, o_corrector_overrun, o_vector_error;
   logic        o_read_halt, o_crc_mismatch, o_crc_irq, o_buf_valid, gs, pok;
   int          fails, checks_done, cyc, sc, pcnt, n, k, c;
   logic [1:0]  pm;
   logic [7:0]  pd, p, e, fb;
   logic [33:0] pbody;
   int          fn[4] = '{12, 13, 6, 7};
   int          fh[4] = '{4, 4, 14, 14};
   wof_link i_wof_link (.*);
   wof_fix_partner i_wof_fix_partner (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
      .i_serial(o_fix_serial), .i_mode(pm), .i_delay(pd), .o_ready(i_fix_ready),
      .o_fault(i_fix_fault), .o_body(pbody), .o_crc_ok(pok), .o_count(pcnt));
   // ============================================================
   // Helpers
   function automatic logic [7:0] crcb(input logic [7:0] c0, input logic [7:0] d);
      logic [7:0] r;
      r = c0;
      for (int j = 7; j >= 0; j--) r = {r[6:0], 1'b0} ^ ((r[7] ^ d[j]) ? 8'h85 : 8'h00);
      return r;
   endfunction
   task automatic tk(input int m = 1);
      repeat (m) @(posedge i_ref_clk);
      #1;
   endtask
   task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic give_verdict;
      if (fails == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic rst;
      i_reset = 1'b1;
      tk(5);
      i_reset = 1'b0;
      tk(3);
   endtask
   task automatic vec;
      a = $urandom;
      p = $urandom;
      i_vec_addr = a;
      i_vec_pattern = p;
      i_vec_valid = 1'b1;
      for (k = 0; k < 900 && o_vec_accept !== 1'b1; k++) tk();
      i_vec_valid = 1'b0;
   endtask
   // Eleven byte times after a good ID; pulses sit well inside the window
   task automatic flag(input int np, input int hi);
      int m, ph;
      m = 0;
      sc = 0;
      gs = 1'b0;
      i_id_ok = 1'b1;
      tk();
      i_id_ok = 1'b0;
      for (int b = 0; b < 11; b++) begin
         i_pseudo_mark = b == 1 && i_id_voting_met;
         i_byte_tick = 1'b1;
         tk();
         i_byte_tick = 1'b0;
         i_pseudo_mark = 1'b0;
         for (int q = 1; q < 48; q++) begin
            ph = (q - 1) % (hi + 6);
            i_raw_read_input = b > 3 && b < 8 && m < np && q < 41 && ph < hi;
            if (i_raw_read_input && ph == hi - 1) m++;
            tk();
         end
      end
   endtask
   // ============================================================
   // Clocks, monitor and time limit
   initial begin
      i_ref_clk = 1'b0;
      forever #10 i_ref_clk = ~i_ref_clk;
   end
   initial begin
      i_reference_double_clock = 1'b0;
      forever begin
         tk(2);
         i_reference_double_clock = ~i_reference_double_clock;
      end
   end
   always @(posedge i_ref_clk) begin
      cyc++;
      if (o_flag_byte_strobe === 1'b1) begin
         sc++;
         fb = o_flag_byte;
      end
      if (o_disk_write_gate === 1'b1) gs = 1'b1;
      if (cyc == 20000) begin
         fails++;
         give_verdict();
      end
   end
   // ============================================================
   // Scenarios
   initial begin
      {i_raw_read_input, i_byte_tick, i_id_ok, i_pseudo_mark, i_id_voting_met, i_sm_met,
       i_data_field, i_sector_end, i_write_sector, i_read_sector, i_flag_abort_en, i_need_sm,
       i_need_id, i_need_flag_clear, i_error_reset, i_vec_valid, i_nrz_start, i_nrz_valid,
       i_nrz_check, i_crc_irq_en, i_erasure_en, i_rll_violation, i_bad_decode, i_resync_used,
       i_lock_lost} = 25'h0;
      {i_op_mode, i_vec_addr, i_vec_pattern, i_nrz_byte, i_nrz_remote, pm, pd} = 59'h0;
      i_reset = 1'b1;
      void'($urandom(32'h3BE5A57C));
      rst;
      chk("checksum after reset", o_nrz_crc, 8'hFF);
      // Back-to-back vectors, the partner answering promptly then slowly
      for (n = 0; n < 5; n++) begin
         pd = n == 0 ? 8'h00 : 8'($urandom % 40);
         c = pcnt;
         vec;
         for (k = 0; k < 300 && pcnt == c; k++) tk();
         chk("vector body", pbody, {4'hD, a, p});
         chk("vector checksum", pok, 1'b1);
      end
      chk("no vector error", o_vector_error, 1'b0);
      for (n = 1; n < 3; n++) begin
         rst;
         i_read_sector = 1'b1;
         pm = n[1:0];
         vec;
         for (k = 0; k < 300 && o_vector_error !== 1'b1; k++) tk();
         chk("vector error", o_vector_error, 1'b1);
         chk("read halt", o_read_halt, 1'b1);
         {i_vec_valid, i_sector_end} = 2'h3;
         tk();
         chk("overrun", o_corrector_overrun, 1'b1);
         {i_vec_valid, i_sector_end, i_error_reset} = 3'h1;
         tk();
         i_error_reset = 1'b0;
         chk("error reset", {o_vector_error, o_read_halt, o_corrector_overrun}, 3'h0);
      end
      rst;
      pm = 2'h0;
      i_read_sector = 1'b0;
      i_write_sector = 1'b1;
      i_crc_irq_en = 1'b1;
      e = 8'hFF;
      i_nrz_start = 1'b1;
      i_nrz_valid = 1'b1;
      i_nrz_byte = 8'h0D;
      for (n = 0; n < 24; n++) begin
         e = crcb(e, i_nrz_byte);
         tk();
         i_nrz_start = 1'b0;
         i_nrz_byte = $urandom;
      end
      i_nrz_valid = 1'b0;
      tk();
      chk("data checksum", o_nrz_crc, e);
      for (n = 0; n < 2; n++) begin
         i_nrz_check = 1'b1;
         i_nrz_remote = n == 0 ? e : ~e;
         tk();
         i_nrz_check = 1'b0;
         tk();
         chk("checksum mismatch", o_crc_mismatch, n[0]);
         chk("checksum irq", o_crc_irq, n[0]);
      end
      i_nrz_start = 1'b1;
      tk();
      i_nrz_start = 1'b0;
      chk("checksum preset", o_nrz_crc, 8'hFF);
      {i_write_sector, i_read_sector, i_erasure_en} = 3'h3;
      for (n = 0; n < 5; n++) begin
         {i_lock_lost, i_resync_used, i_bad_decode, i_rll_violation} = 4'h1 << n;
         i_nrz_valid = 1'b1;
         i_nrz_byte = 8'hA5;
         tk();
         chk("buffer byte", o_buf_byte, n < 4 ? 8'h01 << n : 8'hA5);
         chk("buffer strobe", o_buf_valid, 1'b1);
         i_nrz_valid = 1'b0;
         tk();
      end
      {i_read_sector, i_erasure_en, i_write_sector, i_data_field, i_need_sm} = 5'h07;
      for (n = 0; n < 2; n++) begin
         i_sm_met = n[0];
         tk(3);
         chk("write gate", o_disk_write_gate, n[0]);
      end
      {i_data_field, i_need_sm, i_need_flag_clear, i_flag_abort_en} = 4'h3;
      for (n = 0; n < 4; n++) begin
         rst;
         flag(fn[n], fh[n]);
         chk("flag written", o_flag_written, n[0]);
         chk("write aborted", o_write_aborted, n[0]);
         chk("flag irq", o_flag_irq, n[0]);
         chk("gate during flag", gs, 1'b0);
      end
      {i_write_sector, i_id_voting_met} = 2'h1;
      for (n = 4; n < 6; n++) begin
         rst;
         i_op_mode = n[2:0];
         flag(0, 4);
         chk("flag bytes written", sc, 5);
         chk("flag pattern", fb, 8'hFF);
         chk("gate for flag", gs, 1'b1);
      end
      give_verdict();
   end
endmodule // wof_link_tb
`default_nettype wire
